// [buic_map.svh]
`ifndef BUIC_MAP_SVH
`define BUIC_MAP_SVH
// Bounce time of the switches, in microseconds
`define BUIC_BOUNCE_US 2000
`define BUIC_CLK_MHZ 40
// Stable interval longer than the bounce time: bounce plus one half
`define BUIC_DEBOUNCE_CYCLES ((`BUIC_BOUNCE_US * `BUIC_CLK_MHZ * 3) / 2)
`define BUIC_LED_COUNT 8
`define BUIC_LED_RESET 8'h00
// Configuration status pin is active low: high is dark
`define BUIC_CFG_DARK 1'b1
`endif

// [buic_pkg.sv]
package buic_pkg;
    typedef enum logic [1:0] {
        BUIC_Q_IDLE,
        BUIC_Q_OPEN,
        BUIC_Q_MID
    } buic_quad_e;
    typedef logic [7:0] buic_led_t;
endpackage

// [buic_filt_if.sv]
`timescale 1ns/1ps
interface buic_filt_if #(parameter int N = 8);
    logic [N-1:0] raw;
    logic [N-1:0] clean;
    modport ctrl (output raw, input clean);
    modport filt (input raw, output clean);
endinterface

// [buic_debounce.sv]
`timescale 1ns/1ps
`include "buic_map.svh"
module buic_debounce
    import buic_pkg::*;
#(
    parameter int N = 8,
    parameter logic [N-1:0] IDLE = '0,
    parameter int CYCLES = `BUIC_DEBOUNCE_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    buic_filt_if.filt port
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [N-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
    logic [N-1:0] clean_q, clean_d;
    logic [N-1:0][CW-1:0] cnt_q, cnt_d;
    always_comb begin
        s1_d = port.raw;
        s2_d = s1_q;
        s3_d = s2_q;
    end
    genvar i;
    for (i = 0; i < N; i++) begin : g_bit
        always_comb begin
            clean_d[i] = clean_q[i];
            cnt_d[i] = '0;
            // Only a level held by s2 and s3 alike, differing, and stable long enough
            if (s2_q[i] == s3_q[i] && s3_q[i] != clean_q[i]) begin
                if (cnt_q[i] == CW'(CYCLES - 1)) begin
                    clean_d[i] = s3_q[i];
                end else begin
                    cnt_d[i] = cnt_q[i] + CW'(1);
                end
            end
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= IDLE;
            s2_q <= IDLE;
            s3_q <= IDLE;
            clean_q <= IDLE;
            cnt_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            clean_q <= clean_d;
            cnt_q <= cnt_d;
        end
    end
    assign port.clean = clean_q;
    a_clean_needs_stable: assert property (@(posedge clk) disable iff (!reset_n)
        (clean_q != $past(clean_q)) |-> (clean_q == $past(s3_q)
        && $past(s2_q) == $past(s3_q)))
        else $error("filtered value changed without a stable input");
endmodule

// [buic_top.sv]
`timescale 1ns/1ps
`include "buic_map.svh"
module buic_top
    import buic_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = `BUIC_DEBOUNCE_CYCLES,
    parameter int LED_COUNT = `BUIC_LED_COUNT
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hold_enable,
    input wire logic sleep_request,
    input wire logic button_up,
    input wire logic button_right,
    input wire logic button_down,
    input wire logic button_left,
    input wire logic knob_press,
    input wire logic knob_phase_first,
    input wire logic knob_phase_second,
    input wire logic [3:0] slide_switch,
    input wire logic [LED_COUNT-1:0] led_request,
    input wire logic wake_user_value,
    input wire logic config_done,
    input wire logic config_clearing,
    input wire logic integrity_check_enable,
    input wire logic integrity_error,
    input wire logic prom_attach_jumper,
    input wire logic prom_enable_n,
    input wire logic config_user_value,
    output logic [LED_COUNT-1:0] led_out,
    output logic wake_status_pin,
    output logic config_status_out,
    output logic config_status_oe,
    output logic [3:0] buttons_clean,
    output logic press_clean,
    output logic [3:0] switches_clean,
    output logic step_pulse,
    output logic step_clockwise,
    output logic held
);
    // Bit order of the filtered bus: 3:0 buttons, 4 press, 8:5 switches,
    // 9 first phase, 10 second phase, 11 sleep request.
    localparam int NF = 12;
    localparam logic [NF-1:0] IDLE_LVL = 12'h000;
    buic_filt_if #(.N(NF)) fif ();
    assign fif.raw = {sleep_request, knob_phase_second, knob_phase_first,
                      slide_switch, knob_press, button_left, button_down,
                      button_right, button_up};
    buic_debounce #(.N(NF), .IDLE(IDLE_LVL), .CYCLES(DEBOUNCE_CYCLES)) u_filt (
        .clk(clk),
        .reset_n(reset_n),
        .port(fif.filt)
    );
    logic pa, pb, sleep_f;
    assign pa = fif.clean[9];
    assign pb = fif.clean[10];
    assign sleep_f = fif.clean[11];

    // Hold state
    logic held_q, held_d;
    always_comb begin
        held_d = hold_enable && sleep_f;
    end

    // Quadrature decoder: a cycle starts when one phase opens from the detent,
    // passes through both open, and ends when the first phase to open closes while the other is still open.
    buic_quad_e qst_q, qst_d;
    logic dir_q, dir_d;
    logic step_q, step_d;
    logic stepdir_q, stepdir_d;
    always_comb begin
        qst_d = qst_q;
        dir_d = dir_q;
        step_d = 1'b0;
        stepdir_d = stepdir_q;
        if (held_q) begin
            qst_d = qst_q;
        end else begin
            case (qst_q)
                BUIC_Q_IDLE: begin
                    if (pa && !pb) begin
                        qst_d = BUIC_Q_OPEN;
                        dir_d = 1'b1;
                    end else if (pb && !pa) begin
                        qst_d = BUIC_Q_OPEN;
                        dir_d = 1'b0;
                    end
                end
                BUIC_Q_OPEN: begin
                    if (pa && pb) begin
                        qst_d = BUIC_Q_MID;
                    end else if (!pa && !pb) begin
                        qst_d = BUIC_Q_IDLE;
                    end
                end
                BUIC_Q_MID: begin
                    // Closing order must match the opening order
                    if (!pa && !pb) begin
                        qst_d = BUIC_Q_IDLE;
                    end else if (dir_q ? (!pa && pb) : (pa && !pb)) begin
                        qst_d = BUIC_Q_IDLE;
                        step_d = 1'b1;
                        stepdir_d = dir_q;
                    end
                end
                default: qst_d = BUIC_Q_IDLE;
            endcase
        end
    end

    // Indicator, button, press and switch outputs, frozen while held; wake and config status are not
    logic [LED_COUNT-1:0] led_q, led_d;
    logic wake_q, wake_d;
    logic cfg_q, cfg_d;
    logic cfg_oe_q, cfg_oe_d;
    logic [3:0] btn_q, btn_d;
    logic press_q, press_d;
    logic [3:0] sw_q, sw_d;
    always_comb begin
        led_d = led_q;
        btn_d = btn_q;
        press_d = press_q;
        sw_d = sw_q;
        if (!held_q) begin
            led_d = led_request;
            btn_d = fif.clean[3:0];
            press_d = fif.clean[4];
            sw_d = fif.clean[8:5];
        end
        if (hold_enable) begin
            wake_d = !held_d;
        end else begin
            wake_d = wake_user_value;
        end
        cfg_oe_d = 1'b1;
        if (config_clearing) begin
            cfg_d = 1'b0;
        end else if (!config_done) begin
            cfg_d = 1'b0;
        end else if (prom_attach_jumper) begin
            cfg_d = prom_enable_n;
        end else if (integrity_check_enable) begin
            cfg_d = integrity_error ? 1'b0 : `BUIC_CFG_DARK;
            cfg_oe_d = integrity_error;
        end else begin
            cfg_d = config_user_value;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            held_q <= 1'b0;
            qst_q <= BUIC_Q_IDLE;
            dir_q <= 1'b0;
            step_q <= 1'b0;
            stepdir_q <= 1'b0;
            led_q <= `BUIC_LED_RESET;
            wake_q <= 1'b0;
            cfg_q <= `BUIC_CFG_DARK;
            cfg_oe_q <= 1'b0;
            btn_q <= 4'h0;
            press_q <= 1'b0;
            sw_q <= 4'h0;
        end else begin
            held_q <= held_d;
            qst_q <= qst_d;
            dir_q <= dir_d;
            step_q <= step_d;
            stepdir_q <= stepdir_d;
            led_q <= led_d;
            wake_q <= wake_d;
            cfg_q <= cfg_d;
            cfg_oe_q <= cfg_oe_d;
            btn_q <= btn_d;
            press_q <= press_d;
            sw_q <= sw_d;
        end
    end

    assign led_out = led_q;
    assign wake_status_pin = wake_q;
    assign config_status_out = cfg_q;
    assign config_status_oe = cfg_oe_q;
    assign buttons_clean = btn_q;
    assign press_clean = press_q;
    assign switches_clean = sw_q;
    assign step_pulse = step_q;
    assign step_clockwise = stepdir_q;
    assign held = held_q;

    a_hold_entry: assert property (@(posedge clk) disable iff (!reset_n)
        (hold_enable && sleep_f) |=> held_q)
        else $error("hold not entered");
    a_hold_freezes_leds: assert property (@(posedge clk) disable iff (!reset_n)
        held_q |=> $stable(led_q))
        else $error("indicators changed while held");
    a_wake_shows_hold: assert property (@(posedge clk) disable iff (!reset_n)
        hold_enable |=> (wake_status_pin == !held_q))
        else $error("wake pin does not show hold state");
    a_no_hold_disabled: assert property (@(posedge clk) disable iff (!reset_n)
        !hold_enable |=> !held_q)
        else $error("held while feature disabled");
    a_wake_user_drive: assert property (@(posedge clk) disable iff (!reset_n)
        !hold_enable |=> (wake_status_pin == $past(wake_user_value)))
        else $error("wake pin ignores user value");
    a_step_single: assert property (@(posedge clk) disable iff (!reset_n)
        step_pulse |=> !step_pulse)
        else $error("step pulse longer than one cycle");
    a_step_from_mid: assert property (@(posedge clk) disable iff (!reset_n)
        step_d |-> (qst_q == BUIC_Q_MID && qst_d == BUIC_Q_IDLE))
        else $error("step without full cycle");
    a_step_dir_open: assert property (@(posedge clk) disable iff (!reset_n)
        (qst_q == BUIC_Q_IDLE && pa && !pb && !held_q) |=> dir_q)
        else $error("direction not from first opening phase");
    a_cfg_fail_lit: assert property (@(posedge clk) disable iff (!reset_n)
        (!config_done && !config_clearing) |=> !config_status_out)
        else $error("failed configuration not flagged");
    a_cfg_crc_low: assert property (@(posedge clk) disable iff (!reset_n)
        (config_done && !config_clearing && !prom_attach_jumper
         && integrity_check_enable && integrity_error)
        |=> (!config_status_out && config_status_oe))
        else $error("integrity error not driven low");
    c_step_cw: cover property (@(posedge clk) disable iff (!reset_n)
        step_pulse && step_clockwise);
    c_step_ccw: cover property (@(posedge clk) disable iff (!reset_n)
        step_pulse && !step_clockwise);
    c_hold_cycle: cover property (@(posedge clk) disable iff (!reset_n)
        held_q ##1 !held_q);
endmodule

// [buic_board_model.sv]
`timescale 1ns/1ps
// Board contacts: each pin chatters for BOUNCE cycles after its level changes.
// Released buttons and press read low through pull-downs
// Open knob contacts read high through pull-ups, closed ones low
module buic_board_model #(
    parameter int N = 12,
    parameter int BOUNCE = 3
) (
    input wire logic clk,
    input wire logic [N-1:0] target,
    output logic [N-1:0] pins
);
    int cnt [N];
    logic [N-1:0] last;
    initial begin
        pins = '0;
        last = '0;
        foreach (cnt[i]) cnt[i] = 0;
    end
    always @(posedge clk) begin
        for (int i = 0; i < N; i++) begin
            if (target[i] !== last[i]) begin
                last[i] <= target[i];
                cnt[i] <= BOUNCE;
            end
            if (cnt[i] > 0) begin
                pins[i] <= ~pins[i]; // Chatter
                cnt[i] <= cnt[i] - 1;
            end else begin
                pins[i] <= last[i];
            end
        end
    end
endmodule

// [buic_tb.sv]
`timescale 1ns/1ps
module tb;
    import buic_pkg::*;
    localparam int DB = 4;
    typedef struct {int code; logic [7:0] exp;} buic_note_s;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] tgt = 12'h000;
    logic [11:0] pins;
    logic hold_enable = 1'b0, wake_user_value = 1'b0, config_done = 1'b1;
    logic config_clearing = 1'b0, integrity_check_enable = 1'b0, integrity_error = 1'b0;
    logic prom_attach_jumper = 1'b0, prom_enable_n = 1'b0, config_user_value = 1'b1;
    buic_led_t led_request = 8'h00;
    buic_led_t led_out;
    logic wake_status_pin, config_status_out, config_status_oe, press_clean;
    logic step_pulse, step_clockwise, held;
    logic [3:0] buttons_clean, switches_clean;
    int miscompares = 0;
    int checks_done = 0;
    buic_note_s exp_q[$];
    logic step_q[$];
    string names [8] = '{"led_out", "wake_status_pin", "config_status", "buttons_clean",
        "press_clean", "switches_clean", "held", "config_status_oe"};
    always #12.5 clk = ~clk;
    buic_board_model #(.N(12), .BOUNCE(3)) board_u (.clk(clk), .target(tgt), .pins(pins));
    buic_top #(.DEBOUNCE_CYCLES(DB), .LED_COUNT(8)) dut_u (
        .clk(clk), .reset_n(reset_n), .hold_enable(hold_enable), .sleep_request(pins[11]),
        .button_up(pins[0]), .button_right(pins[1]), .button_down(pins[2]),
        .button_left(pins[3]), .knob_press(pins[4]), .knob_phase_first(pins[5]),
        .knob_phase_second(pins[6]), .slide_switch(pins[10:7]), .led_request(led_request),
        .wake_user_value(wake_user_value), .config_done(config_done),
        .config_clearing(config_clearing), .integrity_check_enable(integrity_check_enable),
        .integrity_error(integrity_error), .prom_attach_jumper(prom_attach_jumper),
        .prom_enable_n(prom_enable_n), .config_user_value(config_user_value),
        .led_out(led_out), .wake_status_pin(wake_status_pin),
        .config_status_out(config_status_out), .config_status_oe(config_status_oe),
        .buttons_clean(buttons_clean), .press_clean(press_clean),
        .switches_clean(switches_clean), .step_pulse(step_pulse),
        .step_clockwise(step_clockwise), .held(held));
    function automatic logic [7:0] seen(int c);
        case (c)
            0: return led_out;
            1: return {7'h00, wake_status_pin};
            2: return {6'h00, config_status_oe, config_status_out};
            3: return {4'h0, buttons_clean};
            4: return {7'h00, press_clean};
            5: return {4'h0, switches_clean};
            6: return {7'h00, held};
            default: return {7'h00, config_status_oe};
        endcase
    endfunction
    // Takes the oldest note when outputs are settled
    always @(negedge clk) begin
        buic_note_s n;
        if (exp_q.size() > 0) begin
            n = exp_q.pop_front();
            checks_done++;
            if (seen(n.code) !== n.exp) begin
                miscompares++;
                $display("unexpected %s: expected %h, seen %h", names[n.code], n.exp,
                    seen(n.code));
            end
        end
    end
    always @(negedge clk) begin
        logic e;
        if (step_pulse === 1'b1) begin
            checks_done++;
            if (step_q.size() == 0) begin
                miscompares++;
                $display("unexpected step_pulse: expected 0, seen 1");
            end else begin
                e = step_q.pop_front();
                if (step_clockwise !== e) begin
                    miscompares++;
                    $display("unexpected step_clockwise: expected %b, seen %b", e,
                        step_clockwise);
                end
            end
        end
    end
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic note(int c, logic [7:0] e);
        exp_q.push_back('{c, e});
        tick(2);
    endtask
    task automatic sw(logic [11:0] t);
        tgt <= t;
        tick(4 * DB + 8);
    endtask
    task automatic turn(logic cw);
        logic [7:0] seq;
        seq = cw ? 8'h2D : 8'h1E;
        step_q.push_back(cw);
        for (int k = 0; k < 4; k++) sw({5'h00, seq[2*k+:2], 5'h00});
    endtask
    task automatic cfg(logic [6:0] v, int c, logic [7:0] e);
        {config_user_value, prom_enable_n, integrity_error, integrity_check_enable,
            prom_attach_jumper, config_done, config_clearing} <= v;
        tick(1);
        note(c, e);
    endtask
    task automatic tally_and_finish();
        if (step_q.size() != 0) begin
            miscompares++;
            $display("unexpected step_count: expected 0, seen %0d", step_q.size());
        end
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        logic [31:0] r;
        void'($urandom(20));
        exp_q.push_back('{0, 8'h00});
        exp_q.push_back('{2, 8'h01});
        exp_q.push_back('{6, 8'h00});
        tick(3);
        reset_n <= 1'b1;
        $display("test reset finished");
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            led_request <= r[7:0];
            tick(1);
            note(0, r[7:0]);
        end
        $display("test indicators finished");
        for (int i = 0; i < 3; i++) begin
            r = $urandom & 32'h79F;
            sw(r[11:0]);
            note(3, {4'h0, r[3:0]});
            note(4, {7'h00, r[4]});
            note(5, {4'h0, r[10:7]});
        end
        sw(12'h000);
        $display("test inputs finished");
        turn(1'b1);
        turn(1'b1);
        turn(1'b0);
        sw(12'h020);
        sw(12'h000);
        turn(1'b0);
        $display("test knob finished");
        hold_enable <= 1'b1;
        led_request <= 8'hA5;
        sw(12'h800);
        note(6, 8'h01);
        note(1, 8'h00);
        led_request <= 8'h3C;
        tick(2);
        note(0, 8'hA5);
        sw(12'h000);
        note(6, 8'h00);
        note(1, 8'h01);
        note(0, 8'h3C);
        hold_enable <= 1'b0;
        wake_user_value <= 1'b1;
        sw(12'h800);
        note(6, 8'h00);
        note(1, 8'h01);
        wake_user_value <= 1'b0;
        tick(1);
        note(1, 8'h00);
        sw(12'h000);
        $display("test hold finished");
        cfg(7'h43, 2, 8'h02);
        cfg(7'h40, 2, 8'h02);
        cfg(7'h66, 2, 8'h03);
        cfg(7'h46, 2, 8'h02);
        cfg(7'h5A, 2, 8'h02);
        cfg(7'h4A, 7, 8'h00);
        cfg(7'h42, 2, 8'h03);
        cfg(7'h02, 2, 8'h02);
        $display("test config status finished");
        tally_and_finish();
    end
endmodule
